// File: pkg/csp_map.vh
/*
 Constants for the configurable serial port: APB register map, field
 positions, reset values, rate table and timing figures.
 Assumes inclusion by bare name from files under hdl/.
*/
// Contract
// (R1) Six rates 300 to 9600 baud
// (R2) Factory rate is 9600 baud
// (R3) No parity 8 bits, else 7
// (R4) Factory format no parity, 8 bits
// (R5) Exactly one start bit
// (R6) Exactly two stop bits
// (R7) Frame spans start through last stop
// (R8) Settings persist across remote reset
// (R9) Settings change only via local path
// (R10) Drive DTR, monitor DSR
// (R11) Commit applies; same values show no-change 1 s
// (R12) Cancel discards pending selections
// (R13) DTR false when receive buffer full
// (R14) Far end stops within ten characters; DTR drops only at FIFO full, RX_FULL 100 exceeds depth 32
// (R15) Sample DSR before each character
// (R16) Hold DTR false until response sent
// (R17) Idle high, LSB first, parity last
// (R18) Parity makes ones count even/odd
`ifndef CSP_MAP_VH
`define CSP_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CSP_REG_TXDATA 12'h000
`define CSP_REG_RXDATA 12'h004
`define CSP_REG_STATUS 12'h008
`define CSP_REG_PEND 12'h00c
`define CSP_REG_CMD 12'h010
`define CSP_REG_ACTIVE 12'h014
`define CSP_REG_RESP 12'h018

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSP_CFG_RATE_LSB 0
`define CSP_CFG_RATE_MSB 2
`define CSP_CFG_PAR_LSB 4
`define CSP_CFG_PAR_MSB 5
`define CSP_CMD_COMMIT 0
`define CSP_CMD_CANCEL 1
`define CSP_RESP_DONE 0

// ----------------------------------------
// Encodings and factory values
// ----------------------------------------
`define CSP_RATE_300 3'h0
`define CSP_RATE_600 3'h1
`define CSP_RATE_1200 3'h2
`define CSP_RATE_2400 3'h3
`define CSP_RATE_4800 3'h4
`define CSP_RATE_9600 3'h5
`define CSP_PAR_NONE 2'h0
`define CSP_PAR_EVEN 2'h1
`define CSP_PAR_ODD 2'h2
`define CSP_RATE_RESET `CSP_RATE_9600
`define CSP_PAR_RESET `CSP_PAR_NONE

// ----------------------------------------
// Timing
// ----------------------------------------
`define CSP_CLK_HZ 200000000
`define CSP_OVERSAMPLE 16
`define CSP_NOCHG_MS 1000
`define CSP_NEWLINE 8'h0a
`define CSP_RX_FULL_LEVEL 100
`define CSP_STOP_BITS 4'h2
`define CSP_BAUD_MAX 9600

`endif

// File: hdl/csp_fifo.v
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes a single clock and active-low asynchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module csp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire ref_clk_i, // Clock
    input wire rst_b_i, // Reset, active low
    input wire [WIDTH-1:0] in_data_i, // Write data
    input wire in_valid_i, // Write request
    output wire in_ready_o, // Not full
    output wire [WIDTH-1:0] out_data_o, // Head word
    output wire out_valid_o, // Not empty
    input wire out_ready_i, // Pop
    output wire [AW:0] level_o // Fill level
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push = in_valid_i && (count != DEPTH[AW:0]);
    wire pop = out_ready_i && (count != {(AW+1){1'b0}});

    assign in_ready_o = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr];
    assign level_o = count;

    always @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: hdl/csp_top.v
/*
 Configurable serial port: APB register file, persistent rate/parity
 settings with commit/cancel, transmitter, receiver with receive FIFO,
 DTR/DSR handshake.
 Assumes synchronous serial and handshake inputs, one 200 MHz clock.
*/
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "csp_map.vh"
module csp_top #(
    parameter RX_DEPTH = 32,
    parameter RX_AW = 5,
    parameter RX_FULL = `CSP_RX_FULL_LEVEL,
    parameter CLK_HZ = `CSP_CLK_HZ,
    parameter NOCHG_CYCLES = CLK_HZ / 1000 * `CSP_NOCHG_MS
) (
    input wire ref_clk_i, // 200 MHz clock
    input wire rst_b_i, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [11:0] paddr, // APB address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error
    input wire rxd_i, // Serial input
    output reg txd_o, // Serial output
    output reg dtr_o, // Ready to receive, high true
    input wire dsr_i, // Far end ready, high true
    input wire cfg_nvm_valid_i, // Stored settings present
    input wire [2:0] cfg_nvm_rate_i, // Stored rate code
    input wire [1:0] cfg_nvm_par_i, // Stored parity code
    output reg cfg_save_o, // Pulse: store active settings
    output reg nochg_o // No-change indication
);
    // ----------------------------------------
    // Settings
    // ----------------------------------------
    reg [2:0] act_rate;
    reg [1:0] act_par;
    reg [2:0] pend_rate;
    reg [1:0] pend_par;
    reg loaded;
    reg [31:0] nochg_cnt;

    // ----------------------------------------
    // Baud divider: 1/16-bit tick, slower rates by doubling
    // ----------------------------------------
    localparam integer BIT_DIV = (CLK_HZ + `CSP_OVERSAMPLE * `CSP_BAUD_MAX / 2) / (`CSP_OVERSAMPLE * `CSP_BAUD_MAX);
    wire [15:0] div_max = (BIT_DIV[15:0] << (`CSP_RATE_9600 - act_rate)) - 16'h0001; // R1
    reg [15:0] div_cnt;
    reg tick;
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_cnt <= 16'h0000;
            tick <= 1'b0;
        end else begin
            tick <= (div_cnt == 16'h0000);
            div_cnt <= (div_cnt == 16'h0000) ? div_max : div_cnt - 1'b1;
        end
    end

    wire par_en = (act_par != `CSP_PAR_NONE);
    wire [3:0] nbits = par_en ? 4'h7 : 4'h8; // R3 R4
    wire par_odd = (act_par == `CSP_PAR_ODD);

    // ----------------------------------------
    // Register bus and response flow
    // ----------------------------------------
    reg [7:0] tx_hold;
    reg tx_full;
    reg resp_pend;
    wire acc = psel && penable && !pready;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire [7:0] rx_head;
    wire rx_nempty;
    wire [RX_AW:0] rx_level;
    wire rx_pop = rd && (paddr == `CSP_REG_RXDATA) && rx_nempty;
    wire tx_take;
    reg [31:0] next_prdata;
    reg next_err;
    reg [7:0] rx_byte;
    reg rx_push;
    wire rx_in_ready;

    always @* begin
        next_prdata = 32'h00000000;
        next_err = 1'b0;
        case (paddr)
            `CSP_REG_TXDATA: next_prdata = {24'h000000, tx_hold};
            `CSP_REG_RXDATA: next_prdata = {23'h000000, rx_nempty, rx_head};
            `CSP_REG_STATUS: next_prdata = {20'h00000, nochg_o, resp_pend, dsr_i, dtr_o,
                                          {(6-RX_AW){1'b0}}, rx_level, tx_full};
            `CSP_REG_PEND: next_prdata = {26'h0000000, pend_par, 1'b0, pend_rate};
            `CSP_REG_CMD: next_prdata = 32'h00000000;
            `CSP_REG_ACTIVE: next_prdata = {26'h0000000, act_par, 1'b0, act_rate};
            `CSP_REG_RESP: next_prdata = {31'h00000000, resp_pend};
            default: next_err = 1'b1;
        endcase
    end

    wire commit = wr && (paddr == `CSP_REG_CMD) && pwdata[`CSP_CMD_COMMIT];
    wire cancel = wr && (paddr == `CSP_REG_CMD) && pwdata[`CSP_CMD_CANCEL];
    wire same = (pend_rate == act_rate) && (pend_par == act_par);
    wire pend_rate_ok = (pwdata[`CSP_CFG_RATE_MSB:`CSP_CFG_RATE_LSB] <= `CSP_RATE_9600);
    wire pend_par_ok = (pwdata[`CSP_CFG_PAR_MSB:`CSP_CFG_PAR_LSB] != 2'h3);

    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            act_rate <= `CSP_RATE_RESET; // R2 R4
            act_par <= `CSP_PAR_RESET;
            pend_rate <= `CSP_RATE_RESET;
            pend_par <= `CSP_PAR_RESET;
            loaded <= 1'b0;
            cfg_save_o <= 1'b0;
            nochg_o <= 1'b0;
            nochg_cnt <= 32'h00000000;
            tx_hold <= 8'h00;
            tx_full <= 1'b0;
            resp_pend <= 1'b0;
        end else begin
            pready <= acc;
            pslverr <= acc && next_err;
            prdata <= rd ? next_prdata : 32'h00000000;
            cfg_save_o <= 1'b0;
            if (!loaded) begin
                // Stored settings restored once after reset
                loaded <= 1'b1; // R8
                if (cfg_nvm_valid_i && cfg_nvm_rate_i <= `CSP_RATE_9600 && cfg_nvm_par_i != 2'h3) begin
                    act_rate <= cfg_nvm_rate_i;
                    act_par <= cfg_nvm_par_i;
                    pend_rate <= cfg_nvm_rate_i;
                    pend_par <= cfg_nvm_par_i;
                end
            end else if (wr && paddr == `CSP_REG_PEND && pend_rate_ok && pend_par_ok) begin
                pend_rate <= pwdata[`CSP_CFG_RATE_MSB:`CSP_CFG_RATE_LSB]; // R9
                pend_par <= pwdata[`CSP_CFG_PAR_MSB:`CSP_CFG_PAR_LSB];
            end else if (commit) begin
                act_rate <= pend_rate; // R11
                act_par <= pend_par;
                cfg_save_o <= !same; // R8
                if (same) begin
                    nochg_o <= 1'b1; // R11
                    nochg_cnt <= NOCHG_CYCLES;
                end
            end else if (cancel) begin
                pend_rate <= act_rate; // R12
                pend_par <= act_par;
            end
            if (nochg_o && !(commit && same)) begin
                if (nochg_cnt <= 32'h00000001) begin
                    nochg_o <= 1'b0;
                end
                nochg_cnt <= nochg_cnt - 1'b1;
            end
            if (wr && paddr == `CSP_REG_TXDATA && !tx_full) begin
                tx_hold <= pwdata[7:0];
                tx_full <= 1'b1;
            end else if (tx_take) begin
                tx_full <= 1'b0;
            end
            // Set beats clear
            if (rx_push && rx_byte == `CSP_NEWLINE) begin
                resp_pend <= 1'b1; // R16
            end else if (wr && paddr == `CSP_REG_RESP && pwdata[`CSP_RESP_DONE]) begin
                resp_pend <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    localparam TX_IDLE = 2'h0;
    localparam TX_START = 2'h1;
    localparam TX_DATA = 2'h2;
    localparam TX_STOP = 2'h3;
    reg [1:0] tx_st;
    reg [3:0] tx_sub;
    reg [3:0] tx_bit;
    reg [8:0] tx_sh;
    wire par_bit = (^tx_hold[6:0]) ^ par_odd; // R18
    assign tx_take = (tx_st == TX_IDLE) && tx_full && dsr_i && !wr; // R15
    wire bit_end = tick && (tx_sub == 4'hf);

    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_st <= TX_IDLE;
            tx_sub <= 4'h0;
            tx_bit <= 4'h0;
            tx_sh <= 9'h000;
            txd_o <= 1'b1;
        end else begin
            if (tick) begin
                tx_sub <= tx_sub + 1'b1;
            end
            case (tx_st)
                TX_IDLE: begin
                    txd_o <= 1'b1; // R17
                    if (tx_take) begin
                        tx_sh <= par_en ? {1'b0, par_bit, tx_hold[6:0]} : {1'b0, tx_hold}; // R17
                        tx_bit <= par_en ? 4'h8 : 4'h8;
                        tx_sub <= 4'h0;
                        tx_st <= TX_START;
                        txd_o <= 1'b0; // R5
                    end
                end
                TX_START: begin
                    if (bit_end) begin
                        txd_o <= tx_sh[0];
                        tx_sh <= {1'b1, tx_sh[8:1]};
                        tx_bit <= tx_bit - 1'b1;
                        tx_st <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (bit_end) begin
                        if (tx_bit == 4'h0) begin
                            txd_o <= 1'b1; // R6
                            tx_bit <= `CSP_STOP_BITS - 4'h1;
                            tx_st <= TX_STOP;
                        end else begin
                            txd_o <= tx_sh[0];
                            tx_sh <= {1'b1, tx_sh[8:1]};
                            tx_bit <= tx_bit - 1'b1;
                        end
                    end
                end
                TX_STOP: begin
                    if (bit_end) begin
                        if (tx_bit == 4'h0) begin
                            tx_st <= TX_IDLE; // R7
                        end else begin
                            tx_bit <= tx_bit - 1'b1;
                        end
                    end
                end
                default: tx_st <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    localparam RX_IDLE = 2'h0;
    localparam RX_START = 2'h1;
    localparam RX_DATA = 2'h2;
    localparam RX_STOP = 2'h3;
    reg [1:0] rx_st;
    reg [3:0] rx_sub;
    reg [3:0] rx_cnt;
    reg [8:0] rx_sh;
    wire rx_mid = tick && (rx_sub == 4'h7);

    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_st <= RX_IDLE;
            rx_sub <= 4'h0;
            rx_cnt <= 4'h0;
            rx_sh <= 9'h000;
            rx_byte <= 8'h00;
            rx_push <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            if (tick) begin
                rx_sub <= rx_sub + 1'b1;
            end
            case (rx_st)
                RX_IDLE: begin
                    if (!rxd_i) begin
                        rx_sub <= 4'h0;
                        rx_st <= RX_START; // R5
                    end
                end
                RX_START: begin
                    if (rx_mid) begin
                        rx_st <= rxd_i ? RX_IDLE : RX_DATA;
                        rx_cnt <= par_en ? 4'h8 : nbits; // R3
                    end
                end
                RX_DATA: begin
                    if (rx_mid) begin
                        rx_sh <= {rxd_i, rx_sh[8:1]}; // R17
                        rx_cnt <= rx_cnt - 1'b1;
                        if (rx_cnt == 4'h1) begin
                            rx_st <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_mid) begin
                        rx_st <= RX_IDLE;
                        rx_push <= rxd_i;
                        rx_byte <= par_en ? {1'b0, rx_sh[7:1]} : rx_sh[8:1];
                    end
                end
                default: rx_st <= RX_IDLE;
            endcase
        end
    end

    csp_fifo #(
        .WIDTH(8),
        .DEPTH(RX_DEPTH),
        .AW(RX_AW)
    ) u_rx_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .in_data_i(rx_byte),
        .in_valid_i(rx_push),
        .in_ready_o(rx_in_ready),
        .out_data_o(rx_head),
        .out_valid_o(rx_nempty),
        .out_ready_i(rx_pop),
        .level_o(rx_level)
    );

    // ----------------------------------------
    // Handshake
    // ----------------------------------------
    wire rx_near_full = !rx_in_ready || (rx_level >= RX_FULL);
    always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dtr_o <= 1'b0;
        end else begin
            // R10 R13 R14 R15 R16
            dtr_o <= !rx_near_full && !resp_pend && !(tx_full && !dsr_i);
        end
    end
endmodule
`default_nettype wire

// File: bench/csp_top_chk.sv
/* Port assertions for csp_top.
 Bound to csp_top below; one clock, async active-low reset. */
`timescale 1ns/100ps
`default_nettype none
`include "csp_map.vh"
module csp_top_chk #(
    parameter NOCHG_CYCLES = 50
) (
    input wire logic ref_clk_i, // Clock
    input wire logic rst_b_i, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic txd_o, // Serial out
    input wire logic dtr_o, // Device ready
    input wire logic dsr_i, // Host ready
    input wire logic cfg_save_o, // Save pulse
    input wire logic nochg_o // No-change flag
);
default clocking @(posedge ref_clk_i); endclocking
default disable iff (!rst_b_i);
logic [31:0] ncnt;
logic tx_wait;
// ----------------------------------------
// Length of the no-change indication
// ----------------------------------------
always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        ncnt <= 32'h0;
    end else begin
        ncnt <= nochg_o ? ncnt + 32'h1 : 32'h0;
    end
end
// Character written and not yet started
always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        tx_wait <= 1'b0;
    end else if (psel && penable && !pready && pwrite && paddr == `CSP_REG_TXDATA) begin
        tx_wait <= 1'b1;
    end else if ($fell(txd_o)) begin
        tx_wait <= 1'b0;
    end
end
sequence take_sq;
    psel && penable && !pready;
endsequence
sequence commit_sq;
    take_sq ##0 (pwrite && paddr == `CSP_REG_CMD && pwdata[0]);
endsequence
sequence cancel_sq;
    take_sq ##0 (pwrite && paddr == `CSP_REG_CMD && pwdata[1] && !pwdata[0]);
endsequence
ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
ready_wait_a: assert property (take_sq |=> pready) else $error("access not answered");
err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
start_len_a: assert property ($fell(txd_o) |=> !txd_o [*8]) else $error("start bit too short");
dsr_hold_a: assert property ((tx_wait && !dsr_i) [*2] |-> !dtr_o) else $error("dtr high while output held");
commit_ack_a: assert property (commit_sq |-> ##[1:4] (cfg_save_o || nochg_o)) else $error("commit silent");
cancel_quiet_a: assert property (cancel_sq |=> !cfg_save_o [*4]) else $error("cancel saved");
save_pulse_a: assert property (cfg_save_o |=> !cfg_save_o) else $error("save pulse too long");
nochg_len_a: assert property ($fell(nochg_o) |-> ncnt >= NOCHG_CYCLES - 2 && ncnt <= NOCHG_CYCLES + 2)
    else $error("no-change length wrong");
endmodule
bind csp_top csp_top_chk #(.NOCHG_CYCLES(NOCHG_CYCLES)) u_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txd_o(txd_o), .dtr_o(dtr_o), .dsr_i(dsr_i),
    .cfg_save_o(cfg_save_o), .nochg_o(nochg_o));
`default_nettype wire

// File: bench/csp_host_model.sv
/* Host serial port model: sends and captures frames, drives DSR.
 Assumes the device clock and the bit time in device clocks. */
`timescale 1ns/100ps
`default_nettype none
module csp_host_model #(
    parameter int BIT_CLKS = 20833
) (
    input wire logic clk_i, // Device clock
    input wire logic line_i, // Device serial out
    output var logic line_o, // Device serial in
    output var logic dsr_o, // Host ready
    input wire logic dtr_i // Device ready
);
initial begin
    line_o = 1'b1;
    dsr_o = 1'b1;
end
task set_dsr(input logic v);
    @(posedge clk_i);
    dsr_o <= v;
endtask
// ----------------------------------------
// Frames out and in: start, data, parity, stops
// ----------------------------------------
task send_char(input logic [10:0] f);
    int i;
    @(posedge clk_i);
    while (dtr_i !== 1'b1) @(posedge clk_i);
    for (i = 0; i < 11; i++) begin
        line_o <= f[i];
        repeat (BIT_CLKS) @(posedge clk_i);
    end
    line_o <= 1'b1;
endtask
task recv_char(output logic [10:0] b);
    int i;
    while (line_i !== 1'b0) @(posedge clk_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (i = 0; i < 11; i++) begin
        b[i] = line_i;
        repeat (BIT_CLKS) @(posedge clk_i);
    end
endtask
endmodule
`default_nettype wire

// File: bench/csp_top_tb_top.sv
/* Self-checking bench for csp_top over APB and the serial link.
 Assumes csp_host_model as far side and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`include "csp_map.vh"
module csp_top_tb_top;
localparam int NOCHG = 50;
// Scaled clock rating: 160 clocks per bit at 9600 baud
localparam int CLK = 1536000;
localparam int BIT = 160;
logic ref_clk_i = 1'b0;
logic rst_b_i = 1'b0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0;
logic nv_ok = 1'b0;
logic [2:0] nv_rate = 3'h0;
logic [1:0] nv_par = 2'h0;
wire logic [31:0] prdata;
wire logic pready, pslverr, rxd, txd_o, dtr_o, dsr, cfg_save_o, nochg_o;
int fail_count = 0;
int cmp_count = 0;
int save_cnt = 0;
logic [31:0] rd;
logic er;
logic [10:0] fr;
always #2.5 ref_clk_i = ~ref_clk_i;
always @(posedge ref_clk_i) if (cfg_save_o === 1'b1) save_cnt++;
csp_top #(.CLK_HZ(CLK), .RX_FULL(2), .NOCHG_CYCLES(NOCHG)) u_dut (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_i(rxd), .txd_o(txd_o), .dtr_o(dtr_o), .dsr_i(dsr), .cfg_nvm_valid_i(nv_ok),
    .cfg_nvm_rate_i(nv_rate), .cfg_nvm_par_i(nv_par), .cfg_save_o(cfg_save_o), .nochg_o(nochg_o));
csp_host_model #(.BIT_CLKS(BIT)) u_host (.clk_i(ref_clk_i), .line_i(txd_o), .line_o(rxd), .dsr_o(dsr),
    .dtr_i(dtr_o));
// ----------------------------------------
// Helpers
// ----------------------------------------
function logic [31:0] cfgw(input logic [2:0] r, input logic [1:0] p);
    return {26'h0, p, 1'b0, r};
endfunction
task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
        fail_count++;
        $display("[FAIL] %0t %s: got %h exp %h", $time, m, got, exp);
    end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1 && n++ < 50);
    chk({31'h0, pready}, 32'h1, "apb ready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
endtask
task rdc(input logic [11:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, m);
endtask
task do_reset;
    rst_b_i <= 1'b0;
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
endtask
task wrap_up;
    if (fail_count == 0 && cmp_count > 0) begin
        $display("== PASSED ==");
    end else begin
        $display("== FAILED ==");
    end
    $finish;
endtask
// ----------------------------------------
// Tests
// ----------------------------------------
initial begin
    do_reset();
    chk({30'h0, dtr_o, txd_o}, 32'h3, "idle lines");
    rdc(`CSP_REG_ACTIVE, cfgw(`CSP_RATE_9600, `CSP_PAR_NONE), "factory");
    apb(1'b0, 12'h01c, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped");
    wr(`CSP_REG_PEND, cfgw(`CSP_RATE_9600, `CSP_PAR_EVEN));
    wr(`CSP_REG_CMD, 32'h2);
    rdc(`CSP_REG_ACTIVE, cfgw(`CSP_RATE_9600, `CSP_PAR_NONE), "cancel");
    rdc(`CSP_REG_PEND, cfgw(`CSP_RATE_9600, `CSP_PAR_NONE), "cancel pend");
    wr(`CSP_REG_PEND, cfgw(`CSP_RATE_9600, `CSP_PAR_NONE));
    wr(`CSP_REG_CMD, 32'h1);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, nochg_o}, 32'h1, "no change");
    chk(save_cnt, 0, "no save");
    repeat (NOCHG + 5) @(posedge ref_clk_i);
    chk({31'h0, nochg_o}, 32'h0, "no change end");
    wr(`CSP_REG_PEND, 32'h6);
    rdc(`CSP_REG_PEND, cfgw(`CSP_RATE_9600, `CSP_PAR_NONE), "bad rate");
    wr(`CSP_REG_PEND, cfgw(`CSP_RATE_9600, `CSP_PAR_EVEN));
    wr(`CSP_REG_CMD, 32'h1);
    repeat (3) @(posedge ref_clk_i);
    chk(save_cnt, 1, "save");
    rdc(`CSP_REG_ACTIVE, cfgw(`CSP_RATE_9600, `CSP_PAR_EVEN), "commit");
    u_host.set_dsr(1'b0);
    repeat (4) @(posedge ref_clk_i);
    wr(`CSP_REG_TXDATA, 32'h31);
    repeat (200) @(posedge ref_clk_i);
    chk({30'h0, dtr_o, txd_o}, 32'h1, "held by dsr");
    fork
        u_host.recv_char(fr);
        u_host.set_dsr(1'b1);
    join
    chk({21'h0, fr}, {21'h0, 2'b11, ^7'h31, 7'h31, 1'b0}, "tx frame");
    chk({31'h0, dtr_o}, 32'h1, "dtr back");
    u_host.send_char({2'b11, ^7'h0a, 7'h0a, 1'b0});
    repeat (20) @(posedge ref_clk_i);
    rdc(`CSP_REG_RXDATA, 32'h10a, "rx char");
    chk({31'h0, dtr_o}, 32'h0, "hold-off");
    rdc(`CSP_REG_STATUS, 32'h600, "status");
    rdc(`CSP_REG_ACTIVE, cfgw(`CSP_RATE_9600, `CSP_PAR_EVEN), "link no cfg");
    wr(`CSP_REG_RESP, 32'h1);
    repeat (3) @(posedge ref_clk_i);
    chk({31'h0, dtr_o}, 32'h1, "response done");
    repeat (2) u_host.send_char({2'b11, ^7'h41, 7'h41, 1'b0});
    repeat (4) @(posedge ref_clk_i);
    chk({31'h0, dtr_o}, 32'h0, "buffer full");
    rdc(`CSP_REG_STATUS, 32'h204, "status full");
    rdc(`CSP_REG_RXDATA, 32'h141, "rx full");
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, dtr_o}, 32'h1, "space freed");
    nv_ok <= 1'b1;
    nv_rate <= `CSP_RATE_2400;
    nv_par <= `CSP_PAR_ODD;
    do_reset();
    rdc(`CSP_REG_ACTIVE, cfgw(`CSP_RATE_2400, `CSP_PAR_ODD), "stored cfg");
    for (int r = 0; r < 6; r++) begin
        wr(`CSP_REG_PEND, cfgw(r[2:0], `CSP_PAR_EVEN));
        wr(`CSP_REG_CMD, 32'h1);
        rdc(`CSP_REG_ACTIVE, cfgw(r[2:0], `CSP_PAR_EVEN), "rate");
    end
    chk(save_cnt, 7, "save count");
    wrap_up();
end
initial begin
    repeat (40000) @(posedge ref_clk_i);
    fail_count++;
    $display("[FAIL] %0t watchdog", $time);
    wrap_up();
end
endmodule
`default_nettype wire
